// ---- hdl/ltx_pkg.sv ----
// Purpose: Constants and types for the transmit input port of one channel
// Assumes: 20 MHz system clock; pins arrive asynchronous to it
// Notes: What the line driver sees is a tip/ring mark pair plus enables
//
// What this block does
// - Clock toggling: sample both inputs on falling edge
// - Clock high 16 master cycles: send all ones
// - Clock high, no master clock: return-to-zero mode
// - Return-to-zero needs clock high at least 12 us
// - Return-to-zero pulse width follows input pulse
// - Clock held low: drivers low power, high-Z
// - Bipolar map: 00 space, 10 tip, 01 ring
// - Negative input high over 16 clocks, master clock present: unipolar
// - Unipolar samples positive input on falling edge
package ltx_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned LTX_SYS_CLK_HZ = 20_000_000;
  localparam int unsigned LTX_AOS_MCLK_CYC = 16;
  localparam int unsigned LTX_RZ_MIN_NS = 12_000;
  localparam int unsigned LTX_RZ_MIN_CYC =
    (LTX_RZ_MIN_NS * (LTX_SYS_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned LTX_UNI_TX_LINE_CLOCK_CYC = 16;
  // A stopped line clock: held low with no edge for this long is a held level
  localparam int unsigned LTX_IDLE_NS = 4_000;
  localparam int unsigned LTX_IDLE_CYC =
    (LTX_IDLE_NS * (LTX_SYS_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned LTX_CNT_W = 10;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    LTX_MODE_BIPOLAR  = 3'h0,
    LTX_MODE_UNIPOLAR = 3'h1,
    LTX_MODE_RZ       = 3'h2,
    LTX_MODE_AOS      = 3'h3,
    LTX_MODE_HIZ      = 3'h4
  } ltx_mode_t;

  typedef struct packed {
    logic tip;
    logic ring;
  } ltx_mark_t;

  typedef struct packed {
    ltx_mark_t mark;
    logic      drive_en;
    logic      power_down;
  } ltx_line_t;

endpackage : ltx_pkg

// ---- hdl/ltx_tx_input_port.sv ----
// Purpose: Mode sensing and mark generation for the transmit input port
// Assumes: master_clk_present_i is a level from the clock monitor
// Notes: Line clock and data pins are synchronised before any use
`timescale 1ns/1ps
module ltx_tx_input_port
  import ltx_pkg::*;
#(
  parameter int unsigned RZ_MIN_CYC = LTX_RZ_MIN_CYC,
  parameter int unsigned IDLE_CYC = LTX_IDLE_CYC
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Pins from the framer and the clock monitor
  input wire logic tx_line_clock_i,
  input wire logic tx_positive_in_i,
  input wire logic tx_negative_in_i,
  input wire logic master_clk_present_i,
  // To the line driver
  output ltx_line_t line_o,
  output ltx_mode_t mode_o
);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  // The level timer saturates, so a count it cannot reach never fires
  if (RZ_MIN_CYC < LTX_AOS_MCLK_CYC ||
      RZ_MIN_CYC >= (1 << LTX_CNT_W)) begin : g_bad_rz_min
    $error("RZ_MIN_CYC out of range");
  end
  if (IDLE_CYC < LTX_AOS_MCLK_CYC ||
      IDLE_CYC >= (1 << LTX_CNT_W)) begin : g_bad_idle
    $error("IDLE_CYC out of range");
  end

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  // Both inputs high is not a legal pair; it goes out as a space
  function automatic ltx_mark_t ltx_bipolar_mark(
    input logic pos,
    input logic neg
  );
    return '{tip: pos & ~neg, ring: neg & ~pos};
  endfunction

  // Mode the port falls back to while the line clock toggles
  function automatic ltx_mode_t ltx_nrz_mode(
    input logic uni
  );
    return uni ? LTX_MODE_UNIPOLAR : LTX_MODE_BIPOLAR;
  endfunction

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  // The line clock is sampled like data, never used as a clock
  logic [3:0] pin_raw;
  logic [3:0] pin_s;
  logic clk_dly_q;

  assign pin_raw = {master_clk_present_i, tx_negative_in_i,
                    tx_positive_in_i, tx_line_clock_i};

  for (genvar i = 0; i < 4; i++) begin : g_sync
    logic meta_q;
    logic sync_q;

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        meta_q <= 1'b0;
        sync_q <= 1'b0;
      end else begin
        meta_q <= pin_raw[i];
        sync_q <= meta_q;
      end
    end

    assign pin_s[i] = sync_q;
  end

  // Edge detector compares the second flop of the line clock chain with a one-cycle delayed copy of it
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      clk_dly_q <= 1'b0;
    else
      clk_dly_q <= pin_s[0];
  end

  logic tx_line_clock_s, pos_s, neg_s, mclk_s;
  assign tx_line_clock_s = pin_s[0];
  assign pos_s = pin_s[1];
  assign neg_s = pin_s[2];
  assign mclk_s = pin_s[3];

  logic fall_edge, any_edge;
  assign fall_edge = clk_dly_q & ~tx_line_clock_s;
  assign any_edge = clk_dly_q ^ tx_line_clock_s;

  // ----------------------------------------------------------------
  // Level timer: cycles since the line clock last changed
  // ----------------------------------------------------------------
  logic [LTX_CNT_W-1:0] level_cnt_q;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      level_cnt_q <= '0;
    end else if (any_edge) begin
      level_cnt_q <= '0;
    end else if (level_cnt_q != {LTX_CNT_W{1'b1}}) begin
      level_cnt_q <= level_cnt_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Unipolar select: count falling edges with negative input high
  // ----------------------------------------------------------------
  logic [4:0] uni_cnt_q;
  logic uni_q;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      uni_cnt_q <= 5'h00;
      uni_q <= 1'b0;
    end else if (!mclk_s || !neg_s) begin
      uni_cnt_q <= 5'h00;
      uni_q <= 1'b0;
    end else if (fall_edge) begin
      if (uni_cnt_q != 5'h1f)
        uni_cnt_q <= uni_cnt_q + 5'h01;
      // More than 16 cycles: the 17th edge commits
      if (uni_cnt_q >= 5'(LTX_UNI_TX_LINE_CLOCK_CYC))
        uni_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Mode selection
  // ----------------------------------------------------------------
  ltx_mode_t mode_q, mode_d;

  always_comb begin
    mode_d = ltx_nrz_mode(uni_q);
    if (tx_line_clock_s) begin
      if (mclk_s && level_cnt_q >= LTX_CNT_W'(LTX_AOS_MCLK_CYC))
        mode_d = LTX_MODE_AOS;
      else if (!mclk_s && level_cnt_q >= LTX_CNT_W'(RZ_MIN_CYC))
        mode_d = LTX_MODE_RZ;
      else if (mode_q == LTX_MODE_AOS || mode_q == LTX_MODE_RZ)
        mode_d = mode_q;
    end else if (level_cnt_q >= LTX_CNT_W'(IDLE_CYC)) begin
      mode_d = LTX_MODE_HIZ;
    end else if (mode_q == LTX_MODE_HIZ) begin
      mode_d = mode_q;
    end
    // A single edge after a held level ends the special modes
    if (any_edge && mode_q != LTX_MODE_UNIPOLAR &&
        mode_q != LTX_MODE_BIPOLAR)
      mode_d = ltx_nrz_mode(uni_q);
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      mode_q <= LTX_MODE_HIZ;
    else
      mode_q <= mode_d;
  end

  // ----------------------------------------------------------------
  // Mark generation
  // ----------------------------------------------------------------
  ltx_line_t line_q;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      line_q <= '{mark: '{tip: 1'b0, ring: 1'b0},
                  drive_en: 1'b0, power_down: 1'b1};
    end else begin
      unique case (mode_d)
        LTX_MODE_BIPOLAR: begin
          line_q.drive_en <= 1'b1;
          line_q.power_down <= 1'b0;
          if (fall_edge) begin
            line_q.mark <= ltx_bipolar_mark(pos_s, neg_s);
          end
        end
        LTX_MODE_UNIPOLAR: begin
          line_q.drive_en <= 1'b1;
          line_q.power_down <= 1'b0;
          // Encoding downstream sets polarity; here data rides tip
          if (fall_edge) begin
            line_q.mark.tip <= pos_s;
            line_q.mark.ring <= 1'b0;
          end
        end
        LTX_MODE_RZ: begin
          line_q.drive_en <= 1'b1;
          line_q.power_down <= 1'b0;
          // Level follows level, so the input pulse width carries through
          line_q.mark <= ltx_bipolar_mark(pos_s, neg_s);
        end
        LTX_MODE_AOS: begin
          line_q.drive_en <= 1'b1;
          line_q.power_down <= 1'b0;
          line_q.mark.tip <= 1'b1;
          line_q.mark.ring <= 1'b0;
        end
        LTX_MODE_HIZ: begin
          line_q.drive_en <= 1'b0;
          line_q.power_down <= 1'b1;
          line_q.mark.tip <= 1'b0;
          line_q.mark.ring <= 1'b0;
        end
        default: begin
          line_q <= line_q;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign line_o = line_q;
  assign mode_o = mode_q;

endmodule // ltx_tx_input_port

// ---- testbench/ltx_framer_model.sv ----
// Purpose: Framer model driving line clock and data pins
// Assumes: Line clock of 8 system cycles while running
// Notes: Data moves on the rising line edge, so it is steady at the fall
`timescale 1ns/1ps
module ltx_framer_model (
  // Controls
  input wire logic sys_clk_i,
  input wire logic run_i,
  input wire logic lvl_i,
  input wire logic pos_i,
  input wire logic neg_i,
  // Pins
  output logic lck_o = 1'h0,
  output logic pos_o = 1'h0,
  output logic neg_o = 1'h0
);
  logic [1:0] cnt_q = 2'h0;
  always @(negedge sys_clk_i) begin
    cnt_q <= run_i ? cnt_q + 2'h1 : 2'h0;
    if (!run_i) {lck_o, pos_o, neg_o} <= {lvl_i, pos_i, neg_i};
    else if (cnt_q == 2'h3) lck_o <= !lck_o;
    if (run_i && cnt_q == 2'h3 && !lck_o)
      {pos_o, neg_o} <= {pos_i, neg_i};
  end
endmodule // ltx_framer_model

// ---- testbench/ltx_tx_input_port_assertions.sv ----
// Purpose: Port checks for the transmit input port
// Assumes: Counters see the raw line clock pin
// Notes: Raw counts lead the synced ones, so entry bounds are lower bounds
`timescale 1ns/1ps
module ltx_tx_input_port_assertions
  import ltx_pkg::*;
#(parameter int unsigned RZ_MIN_CYC = 240, IDLE_CYC = 80) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Watched ports
  input wire logic tx_line_clock_i,
  input wire logic master_clk_present_i,
  input wire ltx_line_t line_o,
  input wire ltx_mode_t mode_o
);
  logic [15:0] hi_q, lo_q;
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) {hi_q, lo_q} <= '0;
    else if (tx_line_clock_i) {hi_q, lo_q} <= {hi_q + 16'h1, 16'h0};
    else {hi_q, lo_q} <= {16'h0, lo_q + 16'h1};
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_hiz; mode_o == LTX_MODE_HIZ |->
    !line_o.drive_en && line_o.power_down; endproperty
  a_hiz: assert property (p_hiz) else $error("drive on");
  property p_hiz_in; $rose(mode_o == LTX_MODE_HIZ) |-> lo_q >= IDLE_CYC;
  endproperty
  a_hiz_in: assert property (p_hiz_in) else $error("early off");
  property p_aos; mode_o == LTX_MODE_AOS |->
    line_o.mark.tip && !line_o.mark.ring; endproperty
  a_aos: assert property (p_aos) else $error("no ones");
  property p_aos_in; $rose(mode_o == LTX_MODE_AOS) |->
    hi_q >= LTX_AOS_MCLK_CYC && master_clk_present_i; endproperty
  a_aos_in: assert property (p_aos_in) else $error("early ones");
  property p_rz_in; $rose(mode_o == LTX_MODE_RZ) |->
    hi_q >= RZ_MIN_CYC && !master_clk_present_i; endproperty
  a_rz_in: assert property (p_rz_in) else $error("early rz");
  property p_both; !(line_o.mark.tip && line_o.mark.ring); endproperty
  a_both: assert property (p_both) else $error("both marks");
  property p_uni_in; $rose(mode_o == LTX_MODE_UNIPOLAR) |->
    master_clk_present_i; endproperty
  a_uni_in: assert property (p_uni_in) else $error("bad uni");
  property p_resume; mode_o == LTX_MODE_AOS && $fell(tx_line_clock_i) |->
    ##[1:8] mode_o inside {LTX_MODE_BIPOLAR, LTX_MODE_UNIPOLAR};
  endproperty
  a_resume: assert property (p_resume) else $error("no resume");
endmodule // ltx_tx_input_port_assertions

// ---- testbench/tb_ltx_tx_input_port.sv ----
// Purpose: Self-checking bench for the transmit input port
// Assumes: Framer model makes the line clock; master clock is a level
// Notes: Short mode counts keep the run brief
`timescale 1ns/1ps
bind ltx_tx_input_port ltx_tx_input_port_assertions #(
  .RZ_MIN_CYC(RZ_MIN_CYC), .IDLE_CYC(IDLE_CYC)) u_chk (
  .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .tx_line_clock_i(tx_line_clock_i),
  .master_clk_present_i(master_clk_present_i), .line_o(line_o),
  .mode_o(mode_o));
module tb_ltx_tx_input_port;
  import ltx_pkg::*;
  logic sys_clk_i = 1'h0, rst_b_i = 1'h0, run = 1'h0, lvl = 1'h0;
  logic pos = 1'h0, neg = 1'h0, mclk = 1'h1, lck, tp, tn;
  ltx_line_t line_o;
  ltx_mode_t mode_o;
  int num_errors = 0, tests_run = 0, cyc = 0;
  initial forever #25 sys_clk_i = ~sys_clk_i;
  ltx_framer_model u_fr (.sys_clk_i(sys_clk_i), .run_i(run), .lvl_i(lvl),
    .pos_i(pos), .neg_i(neg), .lck_o(lck), .pos_o(tp), .neg_o(tn));
  ltx_tx_input_port #(.RZ_MIN_CYC(40), .IDLE_CYC(20)) dut (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .tx_line_clock_i(lck),
    .tx_positive_in_i(tp), .tx_negative_in_i(tn),
    .master_clk_present_i(mclk), .line_o(line_o), .mode_o(mode_o));
  task cmp(input string n, input logic [3:0] e, input logic [3:0] s);
    tests_run++;
    if (s !== e) begin
      $display("FAIL %s exp %h got %h", n, e, s);
      num_errors++;
    end
  endtask
  task cm(input ltx_mode_t m);
    cmp("mode", 4'(m), 4'(mode_o));
  endtask
  task ck(input logic [1:0] e);
    cmp("mark", 4'(e), 4'(line_o.mark));
  endtask
  task w(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task end_of_test();
    if (num_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Hang guard: whole run needs about 580 cycles
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      end_of_test();
    end
  end
  task t_bip();
    run <= 1'h1;
    for (int i = 0; i < 4; i++) begin
      {pos, neg} <= 2'(i);
      w(24);
      ck((i == 3) ? 2'h0 : 2'(i));
    end
    cmp("drv", 4'h2, 4'({line_o.drive_en, line_o.power_down}));
  endtask
  task t_aos();
    run <= 1'h0;
    lvl <= 1'h1;
    w(30);
    cm(LTX_MODE_AOS);
    run <= 1'h1;
    w(24);
    cm(LTX_MODE_BIPOLAR);
  endtask
  task t_hiz();
    run <= 1'h0;
    lvl <= 1'h0;
    w(40);
    cm(LTX_MODE_HIZ);
    cmp("drv", 4'h1, 4'({line_o.drive_en, line_o.power_down}));
    run <= 1'h1;
    w(24);
    cm(LTX_MODE_BIPOLAR);
  endtask
  task t_uni();
    neg <= 1'h0;
    w(24);
    neg <= 1'h1;
    w(112);
    cm(LTX_MODE_BIPOLAR);
    w(48);
    cm(LTX_MODE_UNIPOLAR);
    pos <= 1'h1;
    w(24);
    ck(2'h2);
    pos <= 1'h0;
    w(24);
    ck(2'h0);
    neg <= 1'h0;
    w(24);
    cm(LTX_MODE_BIPOLAR);
  endtask
  task t_rz();
    {mclk, run, lvl} <= 3'h1;
    w(30);
    cm(LTX_MODE_BIPOLAR);
    w(60);
    cm(LTX_MODE_RZ);
    pos <= 1'h1;
    w(10);
    ck(2'h2);
    pos <= 1'h0;
    w(10);
    ck(2'h0);
  endtask
  initial begin
    w(4);
    cmp("line", 4'h1, line_o);
    rst_b_i <= 1'h1;
    t_bip();
    t_aos();
    t_hiz();
    t_uni();
    t_rz();
    end_of_test();
  end
endmodule // tb_ltx_tx_input_port
